// [shared/asu_pkg.sv]
`default_nettype none
package asu_pkg;
    // ----------------------------------------
    // Timing of the bit engine
    // ----------------------------------------
    localparam int unsigned OVERSAMPLE = 16;
    localparam logic [4:0] PRE_DIV8_LAST = 5'h07;
    localparam logic [4:0] PRE_DIV32_LAST = 5'h1f;
    localparam int unsigned CHAR_W = 9;
    localparam logic [3:0] CHAR_LAST7 = 4'h6;
    localparam logic [3:0] CHAR_LAST8 = 4'h7;
    localparam logic [3:0] CHAR_LAST9 = 4'h8;
    localparam int unsigned TX_DEPTH = 2;
    // ----------------------------------------
    // Frame options
    // ----------------------------------------
    typedef enum logic [1:0] {LEN_7 = 2'h0, LEN_8 = 2'h1, LEN_9 = 2'h2} asu_len_type;
    typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} asu_par_type;
    typedef enum logic [1:0] {SRC_UNDIV = 2'h0, SRC_DIV8 = 2'h1, SRC_DIV32 = 2'h2} asu_src_type;
    typedef enum logic [1:0] {HS_NONE = 2'h0, HS_CTS = 2'h1, HS_RTS = 2'h2} asu_hs_type;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, ST_START = 5'h02, ST_DATA = 5'h04, ST_PAR = 5'h08, ST_STOP = 5'h10
    } asu_state_type;
endpackage : asu_pkg
`default_nettype wire

// [rtl/asu_buf2.sv]
`default_nettype none
module asu_buf2 #(
    parameter int unsigned W = 9
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    import asu_pkg::*;
    // ----------------------------------------
    // Two-entry store
    // ----------------------------------------
    logic [W-1:0] mem_q [TX_DEPTH];
    logic [W-1:0] mem_d [TX_DEPTH];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic room_q, room_d, avail_q, avail_d;
    logic push, pop;

    always_comb begin
        push = in_valid_i && room_q;
        pop = out_ready_i && avail_q;
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        room_d = (cnt_d != 2'h2);
        avail_d = (cnt_d != 2'h0);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_q <= '{default: '0};
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
            room_q <= 1'b1;
            avail_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            room_q <= room_d;
            avail_q <= avail_d;
        end
    end

    assign in_ready_o = room_q;
    assign out_valid_o = avail_q;
    assign out_data_o = mem_q[rd_q];
endmodule : asu_buf2
`default_nettype wire

// [rtl/asu_uart.sv]
// Function
// [RULE_01] Character length 7, 8 or 9
// [RULE_02] Parity odd, even or none
// [RULE_03] One start, one or two stops
// [RULE_04] Internal rate: source over 16(n+1)
// [RULE_05] External rate: clock pin over 16(n+1)
// [RULE_06] Eight-bit divisor value from software
// [RULE_07] Transmit needs enable, data, clear-to-send
// [RULE_08] Receive needs enable and start bit
// [RULE_09] Transmit interrupt on buffer-to-shifter move
// [RULE_10] Alternate transmit interrupt at frame end
// [RULE_11] Receive interrupt when word reaches buffer
// [RULE_12] Overrun when unread word gets replaced
// [RULE_13] Overrun overwrites buffer, no interrupt
// [RULE_14] Framing error on missing stop bit
// [RULE_15] Parity error on wrong ones count
// [RULE_16] Summary flag for any error
// [RULE_17] Optional inversion of character bits only
// [RULE_18] Optional inversion of both line pins
// [RULE_19] Sleep mode for multi-drop addressing
// [RULE_20] Handshake: CTS, RTS, none, or separate
// [RULE_21] Idle output high, or floating open-drain
// [RULE_22] Sleep accepts only words with MSB set
// [RULE_23] Sixteen ticks per bit, mid-bit sampling
// [RULE_24] RTS low while receiver can accept
`default_nettype none
module asu_uart #(
    parameter int unsigned OS = asu_pkg::OVERSAMPLE
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire asu_pkg::asu_len_type char_len_i,
    input wire asu_pkg::asu_par_type parity_i,
    input wire logic two_stop_i,
    input wire logic ext_clk_sel_i,
    input wire asu_pkg::asu_src_type src_sel_i,
    input wire logic [7:0] brg_div_i,
    input wire asu_pkg::asu_hs_type handshake_i,
    input wire logic sep_pins_i,
    input wire logic sleep_i,
    input wire logic data_inv_i,
    input wire logic pol_inv_i,
    input wire logic open_drain_i,
    input wire logic tx_en_i,
    input wire logic rx_en_i,
    input wire logic tx_irq_sel_i,
    // Transmit data
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [asu_pkg::CHAR_W-1:0] tx_data_i,
    // Receive data
    output logic rx_valid_o,
    input wire logic rx_read_i,
    output logic [asu_pkg::CHAR_W-1:0] rx_data_o,
    // Status
    output logic tx_empty_o,
    output logic tx_busy_o,
    output logic tx_irq_o,
    output logic rx_irq_o,
    output logic overrun_o,
    output logic framing_o,
    output logic parity_err_o,
    output logic err_sum_o,
    input wire logic err_clr_i,
    // Pins
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    input wire logic serial_in_pin_i,
    input wire logic transfer_clock_pin_i,
    input wire logic cts_n_i,
    output logic rts_n_o
);
    import asu_pkg::*;

    initial begin
        if (OS < 4 || OS > 16 || OS % 2 != 0) begin
            $error("OS must be even and 4..16");
        end
    end

    localparam logic [3:0] T_LAST = 4'(OS - 1);
    localparam logic [3:0] T_MID = 4'(OS / 2 - 1);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, ext_s1_q, ext_s2_q, ext_s3_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q} <= 4'hf;
            {ext_s1_q, ext_s2_q, ext_s3_q} <= 3'h0;
        end else begin
            {rx_s1_q, rx_s2_q} <= {serial_in_pin_i, rx_s1_q};
            {cts_s1_q, cts_s2_q} <= {cts_n_i, cts_s1_q};
            {ext_s1_q, ext_s2_q, ext_s3_q} <= {transfer_clock_pin_i, ext_s1_q, ext_s2_q};
        end
    end

    // ----------------------------------------
    // Bit rate generator
    // ----------------------------------------
    logic [4:0] pre_q, pre_d;
    logic [7:0] brg_q, brg_d;
    logic tick_q, tick_d, src_en;
    always_comb begin
        pre_d = pre_q + 5'h01;
        case (src_sel_i)
            SRC_UNDIV: src_en = 1'b1;
            SRC_DIV8: src_en = (pre_q[2:0] == PRE_DIV8_LAST[2:0]);
            SRC_DIV32: src_en = (pre_q == PRE_DIV32_LAST);
            default: src_en = 1'b1;
        endcase
        if (ext_clk_sel_i) begin
            src_en = ext_s2_q && !ext_s3_q; // RULE_05
        end
        brg_d = brg_q;
        tick_d = 1'b0;
        if (src_en) begin
            if (brg_q >= brg_div_i) begin // RULE_04 RULE_06
                brg_d = 8'h00;
                tick_d = 1'b1;
            end else begin
                brg_d = brg_q + 8'h01;
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_q <= 5'h00;
            brg_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            brg_q <= brg_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------
    // Frame shape shared by both directions
    // ----------------------------------------
    logic [3:0] char_last;
    logic par_on;
    always_comb begin
        case (char_len_i) // RULE_01
            LEN_7: char_last = CHAR_LAST7;
            LEN_8: char_last = CHAR_LAST8;
            default: char_last = CHAR_LAST9;
        endcase
        par_on = (parity_i != PAR_NONE); // RULE_02
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    logic buf_valid, pop;
    logic [CHAR_W-1:0] buf_data;
    asu_buf2 #(.W(CHAR_W)) u_txbuf (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(pop),
        .out_data_o(buf_data)
    );

    asu_state_type tx_st_q, tx_st_d;
    logic [CHAR_W-1:0] tx_sh_q, tx_sh_d;
    logic [3:0] tx_bit_q, tx_bit_d, tx_t_q, tx_t_d;
    logic tx_par_q, tx_par_d, tx_stop2_q, tx_stop2_d, tx_line_q, tx_line_d;
    logic tx_irq_d, tx_end, cts_ok, out_d, oe_d, tx_empty_d, tx_busy_d;
    always_comb begin
        tx_st_d = tx_st_q;
        tx_sh_d = tx_sh_q;
        tx_bit_d = tx_bit_q;
        tx_par_d = tx_par_q;
        tx_stop2_d = tx_stop2_q;
        tx_line_d = tx_line_q;
        tx_irq_d = 1'b0;
        pop = 1'b0;
        tx_end = tick_q && (tx_t_q == T_LAST);
        tx_t_d = tick_q ? tx_t_q + 4'h1 : tx_t_q;
        cts_ok = !((handshake_i == HS_CTS || sep_pins_i) && cts_s2_q); // RULE_20
        case (tx_st_q)
            ST_IDLE: begin
                tx_line_d = 1'b1; // RULE_21
                if (tx_en_i && buf_valid && cts_ok) begin // RULE_07
                    pop = 1'b1;
                    tx_sh_d = data_inv_i ? ~buf_data : buf_data; // RULE_17
                    tx_irq_d = !tx_irq_sel_i; // RULE_09
                    tx_st_d = ST_START;
                    tx_t_d = 4'h0;
                    tx_line_d = 1'b0; // RULE_03
                end
            end
            ST_START: if (tx_end) begin
                tx_st_d = ST_DATA;
                tx_bit_d = 4'h0;
                tx_par_d = (parity_i == PAR_ODD);
                tx_line_d = tx_sh_q[0];
            end
            ST_DATA: if (tx_end) begin
                tx_par_d = tx_par_q ^ tx_sh_q[0]; // RULE_15
                tx_sh_d = {1'b0, tx_sh_q[CHAR_W-1:1]};
                tx_bit_d = tx_bit_q + 4'h1;
                if (tx_bit_q == char_last) begin
                    tx_st_d = par_on ? ST_PAR : ST_STOP;
                    tx_line_d = par_on ? tx_par_q ^ tx_sh_q[0] : 1'b1;
                    tx_stop2_d = 1'b0;
                end else begin
                    tx_line_d = tx_sh_q[1];
                end
            end
            ST_PAR: if (tx_end) begin
                tx_st_d = ST_STOP;
                tx_line_d = 1'b1;
            end
            ST_STOP: if (tx_end) begin
                if (two_stop_i && !tx_stop2_q) begin // RULE_03
                    tx_stop2_d = 1'b1;
                end else begin
                    tx_st_d = ST_IDLE;
                    tx_irq_d = tx_irq_sel_i; // RULE_10
                end
            end
            default: tx_st_d = ST_IDLE;
        endcase
        out_d = open_drain_i ? 1'b0 : (tx_line_d ^ pol_inv_i); // RULE_18
        oe_d = open_drain_i ? !(tx_line_d ^ pol_inv_i) : 1'b1; // RULE_21
        // A pop from a full buffer still leaves one word behind
        tx_empty_d = !(buf_valid && !(pop && tx_ready_o)) && !(tx_valid_i && tx_ready_o); // RULE_07
        tx_busy_d = (tx_st_d != ST_IDLE);
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_st_q <= ST_IDLE;
            tx_sh_q <= '0;
            tx_bit_q <= 4'h0;
            tx_t_q <= 4'h0;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
            tx_line_q <= 1'b1;
            tx_irq_o <= 1'b0;
            serial_out_pin_o <= 1'b1;
            serial_out_pin_oe_o <= 1'b1;
            tx_empty_o <= 1'b1;
            tx_busy_o <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            tx_sh_q <= tx_sh_d;
            tx_bit_q <= tx_bit_d;
            tx_t_q <= tx_t_d;
            tx_par_q <= tx_par_d;
            tx_stop2_q <= tx_stop2_d;
            tx_line_q <= tx_line_d;
            tx_irq_o <= tx_irq_d;
            serial_out_pin_o <= out_d;
            serial_out_pin_oe_o <= oe_d;
            tx_empty_o <= tx_empty_d;
            tx_busy_o <= tx_busy_d;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    asu_state_type rx_st_q, rx_st_d;
    logic [CHAR_W-1:0] rx_sh_q, rx_sh_d, rx_buf_d, word;
    logic [3:0] rx_bit_q, rx_bit_d, rx_t_q, rx_t_d;
    logic rx_par_q, rx_par_d, rx_stop2_q, rx_stop2_d, rx_perr_q, rx_perr_d, rx_ferr_q, rx_ferr_d;
    logic rx_line, smp, mid, done, keep, full_d, rx_irq_d, ovr_d, fr_d, pe_d, rts_d;
    always_comb begin
        rx_line = rx_s2_q ^ pol_inv_i; // RULE_18
        rx_st_d = rx_st_q;
        rx_sh_d = rx_sh_q;
        rx_bit_d = rx_bit_q;
        rx_par_d = rx_par_q;
        rx_stop2_d = rx_stop2_q;
        rx_perr_d = rx_perr_q;
        rx_ferr_d = rx_ferr_q;
        rx_t_d = tick_q ? rx_t_q + 4'h1 : rx_t_q;
        mid = tick_q && (rx_t_q == T_MID);
        smp = tick_q && (rx_t_q == T_LAST); // RULE_23
        done = 1'b0;
        case (rx_st_q)
            ST_IDLE: if (rx_en_i && !rx_line) begin // RULE_08
                rx_st_d = ST_START;
                rx_t_d = 4'h0;
            end
            ST_START: if (mid) begin // RULE_23
                rx_st_d = rx_line ? ST_IDLE : ST_DATA;
                rx_t_d = 4'h0;
                rx_bit_d = 4'h0;
                rx_par_d = (parity_i == PAR_ODD);
                rx_stop2_d = 1'b0;
                rx_ferr_d = 1'b0;
                rx_perr_d = 1'b0;
            end
            ST_DATA: if (smp) begin
                rx_sh_d[rx_bit_q] = rx_line;
                rx_par_d = rx_par_q ^ rx_line;
                rx_bit_d = rx_bit_q + 4'h1;
                if (rx_bit_q == char_last) begin
                    rx_st_d = par_on ? ST_PAR : ST_STOP;
                end
            end
            ST_PAR: if (smp) begin
                rx_perr_d = rx_par_q ^ rx_line; // RULE_15
                rx_st_d = ST_STOP;
            end
            ST_STOP: if (smp) begin
                rx_ferr_d = rx_ferr_q || !rx_line; // RULE_14
                if (two_stop_i && !rx_stop2_q) begin
                    rx_stop2_d = 1'b1;
                end else begin
                    rx_st_d = ST_IDLE;
                    done = 1'b1;
                end
            end
            default: rx_st_d = ST_IDLE;
        endcase
        if (ST_START == rx_st_q && mid) begin
            rx_sh_d = '0;
        end
        word = data_inv_i ? (~rx_sh_q & ~({CHAR_W{1'b1}} << (char_last + 4'h1))) : rx_sh_q; // RULE_17
        keep = done && !(sleep_i && !rx_sh_q[char_last]); // RULE_19 RULE_22
        rx_buf_d = keep ? word : rx_data_o; // RULE_13
        full_d = keep || (rx_valid_o && !rx_read_i); // RULE_12
        rx_irq_d = keep && !rx_valid_o; // RULE_11 RULE_13
        ovr_d = (keep && rx_valid_o) || (overrun_o && !err_clr_i); // RULE_12
        fr_d = (keep && rx_ferr_d) || (framing_o && !err_clr_i);
        pe_d = (keep && rx_perr_d) || (parity_err_o && !err_clr_i);
        rts_d = !(rx_en_i && !full_d) || !(handshake_i == HS_RTS || sep_pins_i); // RULE_24 RULE_20
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_st_q <= ST_IDLE;
            rx_sh_q <= '0;
            rx_bit_q <= 4'h0;
            rx_t_q <= 4'h0;
            rx_par_q <= 1'b0;
            rx_stop2_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_data_o <= '0;
            rx_valid_o <= 1'b0;
            rx_irq_o <= 1'b0;
            overrun_o <= 1'b0;
            framing_o <= 1'b0;
            parity_err_o <= 1'b0;
            err_sum_o <= 1'b0;
            rts_n_o <= 1'b1;
        end else begin
            rx_st_q <= rx_st_d;
            rx_sh_q <= rx_sh_d;
            rx_bit_q <= rx_bit_d;
            rx_t_q <= rx_t_d;
            rx_par_q <= rx_par_d;
            rx_stop2_q <= rx_stop2_d;
            rx_perr_q <= rx_perr_d;
            rx_ferr_q <= rx_ferr_d;
            rx_data_o <= rx_buf_d;
            rx_valid_o <= full_d;
            rx_irq_o <= rx_irq_d;
            overrun_o <= ovr_d;
            framing_o <= fr_d;
            parity_err_o <= pe_d;
            err_sum_o <= ovr_d || fr_d || pe_d; // RULE_16
            rts_n_o <= rts_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_tx_load;
        tx_st_q == ST_IDLE && tx_st_d == ST_START;
    endsequence
    sequence s_word_kept;
        keep && rx_valid_o;
    endsequence
    a_tx_start_gate: assert property (s_tx_load |-> tx_en_i && buf_valid && cts_ok) // RULE_07
        else $error("transmit started without its conditions");
    a_tx_irq_load: assert property ((s_tx_load and !tx_irq_sel_i) |=> tx_irq_o ##1 !tx_irq_o) // RULE_09
        else $error("load interrupt missing");
    a_tx_irq_end: assert property (tx_irq_o && $past(tx_irq_sel_i) |-> $past(tx_st_q) == ST_STOP) // RULE_10
        else $error("frame-end interrupt at wrong time");
    a_rx_start_gate: assert property (rx_st_q == ST_IDLE && rx_st_d == ST_START |-> rx_en_i && !rx_line) // RULE_08
        else $error("receive started without start bit");
    a_rx_overrun: assert property (s_word_kept |=> overrun_o && !rx_irq_o && rx_valid_o) // RULE_12
        else $error("overrun not handled");
    a_rx_irq_word: assert property (rx_irq_o |-> rx_valid_o && !$past(rx_valid_o)) // RULE_11
        else $error("receive interrupt without fresh word");
    a_sleep_drop: assert property (done && sleep_i && !rx_sh_q[char_last] |=> $stable(rx_data_o) && !rx_irq_o) // RULE_22
        else $error("sleep mode accepted a non-address word");
    a_err_sum: assert property (err_sum_o == (overrun_o || framing_o || parity_err_o)) // RULE_16
        else $error("error summary mismatch");
    a_idle_high: assert property (tx_st_q == ST_IDLE && !pol_inv_i && !open_drain_i && !pop |=> serial_out_pin_o) // RULE_21
        else $error("idle line not high");
    a_rts_level: assert property (handshake_i == HS_RTS && !rx_en_i |=> rts_n_o) // RULE_24
        else $error("RTS asserted with receiver off");
endmodule : asu_uart
`default_nettype wire

// [testbench/asu_peer.sv]
`default_nettype none
module asu_peer (
    // Clock
    input wire logic sys_clk_i,
    // Line
    input wire logic inv_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lvl = 1'b1;
    // Peer always drives its line, so an idle line is a defined level
    assign line_o = lvl ^ inv_i;
    // Bit 0 is the start bit, then the character LSB first, parity, stops
    function automatic logic [12:0] frame(input logic [8:0] w, input int nb, par, stops, bad);
        logic [12:0] f;
        int n;
        f = '1;
        f[0] = 1'b0;
        for (n = 0; n < nb; n++)
            f[n + 1] = w[n];
        n = nb + 1;
        if (par != 0)
            f[n] = ^(w & 9'((1 << nb) - 1)) ^ (par == 1) ^ (bad == 1);
        if (bad == 2)
            f[n + (par != 0)] = 1'b0;
        return f;
    endfunction : frame
    task automatic send(input logic [8:0] w, input int nb, par, stops, bc, bad);
        logic [12:0] f;
        int n;
        f = frame(w, nb, par, stops, bad);
        for (n = 0; n < nb + 1 + (par != 0) + stops; n++) begin
            lvl = f[n];
            repeat (bc) @(negedge sys_clk_i);
        end
        lvl = 1'b1;
    endtask : send
    // Returns at the last stop sample so a following frame is not missed
    task automatic recv(output logic [12:0] f, input int nb, par, stops, bc);
        int n;
        f = '0;
        for (n = 0; n < 4000 && (line_i ^ inv_i) !== 1'b0; n++)
            @(negedge sys_clk_i);
        if (n < 4000) begin
            f = '1;
            repeat (bc / 2) @(negedge sys_clk_i);
            for (n = 0; n < nb + 1 + (par != 0) + stops; n++) begin
                if (n > 0)
                    repeat (bc) @(negedge sys_clk_i);
                f[n] = line_i ^ inv_i;
            end
        end
    endtask : recv
endmodule : asu_peer
`default_nettype wire

// [testbench/asu_uart_test.sv]
`default_nettype none
module asu_uart_test;
    import asu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rstn_i, two_stop, ext_sel, sep, sleep, dinv, pinv, od, tx_en, rx_en, irq_sel;
    logic tx_valid, tx_ready, rx_valid, rx_read, tx_empty, tx_busy, tx_irq, rx_irq;
    logic ovr, frm, perr, esum, err_clr, sout, sout_oe, sin, cts_n, rts_n;
    logic [8:0] tx_data, rx_data;
    logic [7:0] div;
    logic [1:0] tcnt;
    asu_len_type len;
    asu_par_type par;
    asu_src_type src;
    asu_hs_type hs;
    int n_mismatch = 0, samples_checked = 0, n_tx = 0, n_rx = 0, i, k;
    // Open-drain output floats high through the pull-up
    wire logic line = sout_oe ? sout : 1'b1;
    asu_uart i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .char_len_i(len), .parity_i(par),
        .two_stop_i(two_stop), .ext_clk_sel_i(ext_sel), .src_sel_i(src), .brg_div_i(div),
        .handshake_i(hs), .sep_pins_i(sep), .sleep_i(sleep), .data_inv_i(dinv), .pol_inv_i(pinv),
        .open_drain_i(od), .tx_en_i(tx_en), .rx_en_i(rx_en), .tx_irq_sel_i(irq_sel),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data), .rx_valid_o(rx_valid),
        .rx_read_i(rx_read), .rx_data_o(rx_data), .tx_empty_o(tx_empty), .tx_busy_o(tx_busy),
        .tx_irq_o(tx_irq), .rx_irq_o(rx_irq), .overrun_o(ovr), .framing_o(frm), .parity_err_o(perr),
        .err_sum_o(esum), .err_clr_i(err_clr), .serial_out_pin_o(sout), .serial_out_pin_oe_o(sout_oe),
        .serial_in_pin_i(sin), .transfer_clock_pin_i(tcnt[1]), .cts_n_i(cts_n), .rts_n_o(rts_n));
    asu_peer i_peer (.sys_clk_i(sys_clk_i), .inv_i(pinv), .line_i(line), .line_o(sin));
    // ----------------------------------------
    // Clocks and event counters
    // ----------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // External bit clock at a quarter of the system rate
    always @(negedge sys_clk_i)
        tcnt <= tcnt + 2'h1;
    always @(posedge sys_clk_i) begin
        n_tx <= n_tx + int'(tx_irq === 1'b1);
        n_rx <= n_rx + int'(rx_irq === 1'b1);
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [12:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc
    task automatic wr(input logic [8:0] w);
        int j;
        tx_valid = 1'b1;
        tx_data = w;
        for (j = 0; j < 100; j++) begin
            @(posedge sys_clk_i);
            if (tx_ready === 1'b1)
                break;
        end
        if (j == 100) begin
            n_mismatch++;
            conclude();
        end
        @(negedge sys_clk_i);
        tx_valid = 1'b0;
        @(negedge sys_clk_i);
    endtask : wr
    task automatic rd();
        rx_read = 1'b1;
        cyc(1);
        rx_read = 1'b0;
    endtask : rd
    // Read and clear together, then let the line settle
    task automatic clr();
        {rx_read, err_clr} = 2'b11;
        cyc(1);
        {rx_read, err_clr} = 2'b00;
        cyc(40);
    endtask : clr
    task automatic txf(input logic [8:0] exp, input int nb, par, stops, bc);
        logic [12:0] f;
        i_peer.recv(f, nb, par, stops, bc);
        chk("tx_frame", i_peer.frame(exp, nb, par, stops, 0), f);
    endtask : txf
    task automatic rxf(input logic [8:0] w, exp, input int nb, par, stops, bc);
        i_peer.send(w, nb, par, stops, bc, 0);
        cyc(2);
        chk("rx_data", 13'(exp), 13'(rx_data));
    endtask : rxf
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {two_stop, ext_sel, sep, sleep, dinv, pinv, od, tx_en, rx_en, irq_sel} = '0;
        {tx_valid, rx_read, err_clr, rstn_i, cts_n} = 5'h01;
        {tcnt, tx_data, div} = '0;
        len = LEN_8;
        par = PAR_NONE;
        src = SRC_UNDIV;
        hs = HS_NONE;
        cyc(2);
        chk("reset", 13'h1f, 13'({tx_ready, sout, sout_oe, rts_n, tx_empty}));
        {rstn_i, od} = 2'b11;
        cyc(3);
        chk("float", 13'h0, 13'(sout_oe));
        {od, tx_en, rx_en} = 3'b011;
        cyc(2);
        for (i = 0; i < 3; i++) begin
            len = asu_len_type'(2'(i));
            par = asu_par_type'(2'(i));
            two_stop = (i == 1);
            wr(9'h1a5);
            cyc(4);
            chk("tx_irq", 13'(i + 1), 13'(n_tx));
            txf(9'h1a5, 7 + i, i, 1 + (i == 1), 16);
            rxf(9'h1c3, 9'h1c3 & 9'((1 << (7 + i)) - 1), 7 + i, i, 1 + (i == 1), 16);
            chk("rx_irq", 13'(i + 1), 13'(n_rx));
            rd();
        end
        chk("no_err", 13'h0, 13'({ovr, frm, perr, esum}));
        irq_sel = 1'b1;
        wr(9'h055);
        cyc(4);
        chk("tx_irq_end", 13'h3, 13'(n_tx));
        txf(9'h055, 9, 2, 1, 16);
        cyc(24);
        chk("tx_irq_end", 13'h4, 13'(n_tx));
        irq_sel = 1'b0;
        i_peer.send(9'h0f0, 9, 2, 1, 16, 1);
        cyc(2);
        chk("parity", 13'h3, 13'({frm, perr, esum}));
        clr();
        i_peer.send(9'h0f0, 9, 2, 1, 16, 2);
        cyc(2);
        chk("framing", 13'h5, 13'({frm, perr, esum}));
        clr();
        k = n_rx;
        i_peer.send(9'h011, 9, 2, 1, 16, 0);
        i_peer.send(9'h122, 9, 2, 1, 16, 0);
        cyc(2);
        chk("overrun", 13'h3, 13'({ovr, esum}));
        chk("ovr_data", 13'h122, 13'(rx_data));
        chk("ovr_irq", 13'(k + 1), 13'(n_rx));
        clr();
        sleep = 1'b1;
        len = LEN_8;
        par = PAR_NONE;
        hs = HS_RTS;
        cyc(3);
        chk("rts_ready", 13'h0, 13'(rts_n));
        rx_en = 1'b0;
        cyc(3);
        chk("rts_off", 13'h1, 13'(rts_n));
        rx_en = 1'b1;
        i_peer.send(9'h07f, 8, 0, 1, 16, 0);
        cyc(2);
        chk("sleep_drop", 13'h0, 13'(rx_valid));
        rxf(9'h080, 9'h080, 8, 0, 1, 16);
        chk("rts_full", 13'h1, 13'(rts_n));
        rd();
        {sleep, dinv, pinv} = 3'b011;
        hs = HS_NONE;
        cyc(40);
        wr(9'h035);
        txf(9'h0ca, 8, 0, 1, 16);
        rxf(9'h0ca, 9'h035, 8, 0, 1, 16);
        rd();
        {dinv, pinv, div} = {2'b00, 8'h01};
        src = SRC_DIV8;
        cyc(40);
        wr(9'h02a);
        txf(9'h02a, 8, 0, 1, 256);
        cyc(200);
        src = SRC_DIV32;
        div = 8'h00;
        wr(9'h05c);
        txf(9'h05c, 8, 0, 1, 512);
        cyc(300);
        {ext_sel, div} = {1'b1, 8'h00};
        src = SRC_UNDIV;
        rxf(9'h0a6, 9'h0a6, 8, 0, 1, 64);
        rd();
        ext_sel = 1'b0;
        hs = HS_CTS;
        cyc(40);
        wr(9'h0aa);
        wr(9'h0bb);
        cyc(40);
        chk("cts_hold", 13'h0, 13'({tx_ready, tx_busy, tx_empty}));
        cts_n = 1'b0;
        txf(9'h0aa, 8, 0, 1, 16);
        txf(9'h0bb, 8, 0, 1, 16);
        cyc(16);
        chk("drained", 13'h1, 13'(tx_empty));
        {sep, cts_n} = 2'b11;
        hs = HS_NONE;
        cyc(3);
        wr(9'h011);
        cyc(40);
        chk("sep_pins", 13'h0, 13'({rts_n, tx_busy, tx_empty}));
        conclude();
    end
endmodule : asu_uart_test
`default_nettype wire
